//--- logic/ppc_port_pin_config_regs.sv
// Port pin configuration registers with timer toggle output enables
`timescale 1ns/1ps

// A write strobe stores its data at the edge that samples it, and a read
// strobe loads the held read data at that same edge. Registers that share
// an offset are told apart by the page input; an access that selects none
// of them is ignored and reads back zero.
module ppc_port_pin_config_regs (
	input wire logic clock,
	input wire logic rst_n,
	// Register access port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_page,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Configuration option and shared pin
	input wire logic reset_pin_disable_opt,
	input wire logic shared_pin_in,
	output logic shared_pin_data,
	output logic shared_pin_pullup_en,
	output logic shared_pin_schmitt_sel,
	// Port 3 mode and pin attributes
	output logic [1:0] port3_mode,
	output logic port3_quasi_bidir,
	output logic port3_push_pull,
	output logic port3_input_only,
	output logic port3_open_drain,
	output logic port3_schmitt,
	// Port 0 and 1 thresholds and slew rates
	output logic [7:0] port0_schmitt,
	output logic [7:0] port1_schmitt,
	output logic [7:0] port0_slew_fast,
	output logic [7:0] port1_slew_fast,
	// Timer toggle outputs
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	output logic timer0_toggle_out_en,
	output logic timer1_toggle_out_en,
	output logic timer0_pin_out,
	output logic timer1_pin_out,
	output logic timer0_pin_oe,
	output logic timer1_pin_oe
);

	// Address match, optionally qualified by page
	// A paged register answers only while its own page is selected
	function automatic logic addr_match(
		input logic [7:0] addr,
		input logic [7:0] off,
		input logic paged,
		input logic cur_page,
		input logic want_page
	);
		addr_match = (addr == off) && (!paged || (cur_page == want_page));
	endfunction

	// Write merge that keeps only implemented bits
	function automatic logic [7:0] masked(
		input logic [7:0] data,
		input logic [7:0] mask
	);
		masked = data & mask;
	endfunction

	// Port 3 mode select pair, page 0, bit 0 only
	logic [7:0] p3_mode_low_q;
	logic [7:0] p3_mode_low_d;
	logic [7:0] p3_mode_high_q;
	logic [7:0] p3_mode_high_d;

	// Port 3 input threshold, page 1, bit 0 only
	logic [7:0] p3_thresh_q;
	logic [7:0] p3_thresh_d;

	// Port 0 threshold and slew, page 1, all bits
	logic [7:0] p0_thresh_q;
	logic [7:0] p0_thresh_d;
	logic [7:0] p0_slew_q;
	logic [7:0] p0_slew_d;

	// Port 1 threshold and slew, page 1, all bits
	logic [7:0] p1_thresh_q;
	logic [7:0] p1_thresh_d;
	logic [7:0] p1_slew_q;
	logic [7:0] p1_slew_d;

	// Shared pin and toggle setting, on both pages
	logic [7:0] shared_set_q;
	logic [7:0] shared_set_d;

	// Read data held between read strobes
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// Toggle output state for each timer
	logic t0_pin_q;
	logic t0_pin_d;
	logic t1_pin_q;
	logic t1_pin_d;

	// Per-register selects
	wire logic sel_p3_mode_low;
	wire logic sel_p3_mode_high;
	wire logic sel_p3_thresh;
	wire logic sel_p0_thresh;
	wire logic sel_p0_slew;
	wire logic sel_p1_thresh;
	wire logic sel_p1_slew;
	wire logic sel_shared;

	// Read selection of the addressed register
	wire logic [7:0] read_mux;

	// High while the shared pin is a plain input rather than reset
	wire logic shared_pin_is_gpio;

	// Page 0 holds the port 3 mode pair
	assign sel_p3_mode_low = addr_match(sfr_addr,
		ppc_pkg::OFF_P3_MODE_LOW, 1'b1, sfr_page, ppc_pkg::PAGE_0); // RL5 RL16
	assign sel_p3_mode_high = addr_match(sfr_addr,
		ppc_pkg::OFF_P3_MODE_HIGH, 1'b1, sfr_page, ppc_pkg::PAGE_0); // RL5

	// Page 1 holds the input-type registers
	assign sel_p3_thresh = addr_match(sfr_addr,
		ppc_pkg::OFF_P3_THRESH, 1'b1, sfr_page, ppc_pkg::PAGE_1); // RL7 RL16
	assign sel_p0_thresh = addr_match(sfr_addr,
		ppc_pkg::OFF_P0_THRESH, 1'b1, sfr_page, ppc_pkg::PAGE_1); // RL7
	assign sel_p1_thresh = addr_match(sfr_addr,
		ppc_pkg::OFF_P1_THRESH, 1'b1, sfr_page, ppc_pkg::PAGE_1); // RL7

	// Page 1 holds the slew registers
	assign sel_p0_slew = addr_match(sfr_addr,
		ppc_pkg::OFF_P0_SLEW, 1'b1, sfr_page, ppc_pkg::PAGE_1); // RL9
	assign sel_p1_slew = addr_match(sfr_addr,
		ppc_pkg::OFF_P1_SLEW, 1'b1, sfr_page, ppc_pkg::PAGE_1); // RL9

	// Shared setting register answers on either page
	assign sel_shared = addr_match(sfr_addr,
		ppc_pkg::OFF_SHARED_SET, 1'b0, sfr_page, ppc_pkg::PAGE_0);

	// Any register of this block addressed
	assign sfr_hit = sel_p3_mode_low | sel_p3_mode_high | sel_p3_thresh |
		sel_p0_thresh | sel_p0_slew | sel_p1_thresh | sel_p1_slew |
		sel_shared;

	// Read selection; unmapped addresses read zero
	assign read_mux =
		({8{sel_p3_mode_low}} & p3_mode_low_q) |
		({8{sel_p3_mode_high}} & p3_mode_high_q) |
		({8{sel_p3_thresh}} & p3_thresh_q) |
		({8{sel_p0_thresh}} & p0_thresh_q) |
		({8{sel_p0_slew}} & p0_slew_q) |
		({8{sel_p1_thresh}} & p1_thresh_q) |
		({8{sel_p1_slew}} & p1_slew_q) |
		({8{sel_shared}} & shared_set_q); // RL16

	// Next values of the writable registers
	// Port 3 registers keep bit 0 only
	assign p3_mode_low_d = (sfr_wr && sel_p3_mode_low) ?
		masked(sfr_wdata, ppc_pkg::MASK_P3) : p3_mode_low_q; // RL15
	assign p3_mode_high_d = (sfr_wr && sel_p3_mode_high) ?
		masked(sfr_wdata, ppc_pkg::MASK_P3) : p3_mode_high_q; // RL15
	assign p3_thresh_d = (sfr_wr && sel_p3_thresh) ?
		masked(sfr_wdata, ppc_pkg::MASK_P3) : p3_thresh_q; // RL15

	// Port 0 and 1 registers keep all eight bits
	assign p0_thresh_d = (sfr_wr && sel_p0_thresh) ?
		masked(sfr_wdata, ppc_pkg::MASK_FULL) : p0_thresh_q;
	assign p0_slew_d = (sfr_wr && sel_p0_slew) ?
		masked(sfr_wdata, ppc_pkg::MASK_FULL) : p0_slew_q;
	assign p1_thresh_d = (sfr_wr && sel_p1_thresh) ?
		masked(sfr_wdata, ppc_pkg::MASK_FULL) : p1_thresh_q;
	assign p1_slew_d = (sfr_wr && sel_p1_slew) ?
		masked(sfr_wdata, ppc_pkg::MASK_FULL) : p1_slew_q;

	// Shared setting keeps bits 7, 3, 2 and 0
	assign shared_set_d = (sfr_wr && sel_shared) ?
		masked(sfr_wdata, ppc_pkg::MASK_SHARED) : shared_set_q; // RL15

	// Read data is captured on a read strobe and then held
	// A strobe that selects nothing loads zero, so stale data never lingers
	assign rdata_d = sfr_rd ? read_mux : rdata_q;

	// Port 3 configuration registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			p3_mode_low_q <= ppc_pkg::RST_P3_MODE_LOW; // RL4
			p3_mode_high_q <= ppc_pkg::RST_P3_MODE_HIGH; // RL4
			p3_thresh_q <= ppc_pkg::RST_ZERO; // RL10
		end else begin
			p3_mode_low_q <= p3_mode_low_d;
			p3_mode_high_q <= p3_mode_high_d;
			p3_thresh_q <= p3_thresh_d;
		end
	end

	// Port 0 and 1 threshold and slew registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			p0_thresh_q <= ppc_pkg::RST_ZERO; // RL10
			p0_slew_q <= ppc_pkg::RST_ZERO; // RL10
			p1_thresh_q <= ppc_pkg::RST_ZERO; // RL10
			p1_slew_q <= ppc_pkg::RST_ZERO; // RL10
		end else begin
			p0_thresh_q <= p0_thresh_d;
			p0_slew_q <= p0_slew_d;
			p1_thresh_q <= p1_thresh_d;
			p1_slew_q <= p1_slew_d;
		end
	end

	// Shared pin setting register and read data holder
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shared_set_q <= ppc_pkg::RST_ZERO;
			rdata_q <= ppc_pkg::RST_ZERO;
		end else begin
			shared_set_q <= shared_set_d;
			rdata_q <= rdata_d;
		end
	end

	// Read data comes straight from its flip-flops
	assign sfr_rdata = rdata_q;

	// Port 3 mode from the low/high bit pair
	assign port3_mode = {p3_mode_low_q[0], p3_mode_high_q[0]}; // RL3

	// One-hot mode decode for the pad driver
	always_comb begin
		port3_quasi_bidir = 1'b0;
		port3_push_pull = 1'b0;
		port3_input_only = 1'b0;
		port3_open_drain = 1'b0;
		case (port3_mode)
			// Both bits clear
			ppc_pkg::PPC_QUASI_BIDIR: port3_quasi_bidir = 1'b1; // RL3
			// High bit only
			ppc_pkg::PPC_PUSH_PULL: port3_push_pull = 1'b1; // RL3
			// Low bit only, the reset state
			ppc_pkg::PPC_INPUT_ONLY: port3_input_only = 1'b1; // RL3
			// Both bits set
			ppc_pkg::PPC_OPEN_DRAIN: port3_open_drain = 1'b1; // RL3
			// Unreachable with two bits; falls back to the reset mode
			default: port3_input_only = 1'b1;
		endcase
	end

	// Per-pin threshold selects, set means Schmitt
	assign port0_schmitt = p0_thresh_q; // RL6
	assign port1_schmitt = p1_thresh_q; // RL6
	assign port3_schmitt = p3_thresh_q[0]; // RL6
	assign shared_pin_schmitt_sel =
		shared_set_q[ppc_pkg::BIT_SCHMITT_SEL]; // RL11 RL6

	// Per-pin slew selects, set means high-speed
	assign port0_slew_fast = p0_slew_q; // RL8
	assign port1_slew_fast = p1_slew_q; // RL8

	// Option programmed to 0 frees the pin from its reset role
	// The option is a fixed configuration input and is not stored here
	assign shared_pin_is_gpio = !reset_pin_disable_opt;

	// Pull-up forced on while the pin serves as reset
	assign shared_pin_pullup_en = shared_pin_is_gpio ?
		shared_set_q[ppc_pkg::BIT_PULLUP_EN] : 1'b1; // RL1 RL2

	// Pin data reads the input only when freed, otherwise zero
	assign shared_pin_data = shared_pin_is_gpio & shared_pin_in; // RL14

	// Toggle enables go to their own timers
	assign timer0_toggle_out_en =
		shared_set_q[ppc_pkg::BIT_T0_TOGGLE]; // RL13
	assign timer1_toggle_out_en =
		shared_set_q[ppc_pkg::BIT_T1_TOGGLE]; // RL13

	// Output held at 1 while disabled, flips on overflow when enabled
	// Clearing the enable returns the pin to 1 at the next edge, so a later
	// enable always starts from 1 before its first overflow
	assign t0_pin_d = !timer0_toggle_out_en ? 1'b1 :
		(timer0_overflow ? !t0_pin_q : t0_pin_q); // RL12
	assign t1_pin_d = !timer1_toggle_out_en ? 1'b1 :
		(timer1_overflow ? !t1_pin_q : t1_pin_q); // RL12

	// Toggle output state
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			t0_pin_q <= 1'b1;
			t1_pin_q <= 1'b1;
		end else begin
			t0_pin_q <= t0_pin_d;
			t1_pin_q <= t1_pin_d;
		end
	end

	// Count pins are driven only while toggling is enabled
	// With toggling off the pins are left to the port's own input path
	assign timer0_pin_out = t0_pin_q;
	assign timer1_pin_out = t1_pin_q;
	assign timer0_pin_oe = timer0_toggle_out_en; // RL12
	assign timer1_pin_oe = timer1_toggle_out_en; // RL12

endmodule // ppc_port_pin_config_regs

//--- logic/ppc_pkg.sv
// Package of constants for the port pin configuration register set
// Summary of operation
// RL1: Shared setting bit 7 enables shared pin pull-up
// RL2: Pull-up bit counts only when pin not reset
// RL3: Two port 3 mode bits pick pin mode
// RL4: Port 3 mode low resets 01, high 00
// RL5: Mode high 0xAD, mode low 0xAC, page 0
// RL6: Input-type bit set means Schmitt, clear TTL
// RL7: Input-type registers reachable only on page 1
// RL8: Slew bit set means high-speed, clear normal
// RL9: Slew registers reachable only on page 1
// RL10: Slew and input-type registers reset to zero
// RL11: Shared setting bit 0 picks shared pin threshold
// RL12: Toggle enable makes overflow toggle pin, starts 1
// RL13: Timer 0 and 1 enables control own outputs
// RL14: Shared pin reads input only when option 0
// RL15: Unimplemented bits ignore writes, read zero
// RL16: Shared offsets pick register by current page
package ppc_pkg;

	// Register offsets in the special function register space
	localparam logic [7:0] OFF_P3_MODE_LOW = 8'hAC;
	localparam logic [7:0] OFF_P3_THRESH = 8'hAC;
	localparam logic [7:0] OFF_P3_MODE_HIGH = 8'hAD;
	localparam logic [7:0] OFF_P0_THRESH = 8'hB1;
	localparam logic [7:0] OFF_P0_SLEW = 8'hB2;
	localparam logic [7:0] OFF_P1_THRESH = 8'hB3;
	localparam logic [7:0] OFF_P1_SLEW = 8'hB4;
	localparam logic [7:0] OFF_SHARED_SET = 8'hB5;

	// Page select values
	localparam logic PAGE_0 = 1'b0;
	localparam logic PAGE_1 = 1'b1;

	// Implemented bit masks
	localparam logic [7:0] MASK_P3 = 8'h01;
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [7:0] MASK_SHARED = 8'h8D;

	// Field positions in the shared pin and toggle setting register
	localparam int BIT_PULLUP_EN = 7;
	localparam int BIT_T1_TOGGLE = 3;
	localparam int BIT_T0_TOGGLE = 2;
	localparam int BIT_SCHMITT_SEL = 0;

	// Reset values
	localparam logic [7:0] RST_P3_MODE_LOW = 8'h01;
	localparam logic [7:0] RST_P3_MODE_HIGH = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Port 3 pin modes, in order of the low/high bit pair value
	typedef enum logic [1:0] {
		PPC_QUASI_BIDIR,
		PPC_PUSH_PULL,
		PPC_INPUT_ONLY,
		PPC_OPEN_DRAIN
	} ppc_mode_e;

endpackage

//--- verification/ppc_port_pin_config_regs_asserts.sv
// Checker of the port pin configuration registers, bound to the top
`timescale 1ns/1ps
module ppc_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_page,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic reset_pin_disable_opt,
	input wire logic shared_pin_in,
	input wire logic shared_pin_data,
	input wire logic shared_pin_pullup_en,
	input wire logic [1:0] port3_mode,
	input wire logic port3_input_only,
	input wire logic [7:0] port0_slew_fast,
	input wire logic timer0_overflow,
	input wire logic timer0_toggle_out_en,
	input wire logic timer0_pin_out
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Write strobe aimed at the shared setting register
	wire wr_shr = sfr_wr && sfr_addr == ppc_pkg::OFF_SHARED_SET;
	// Write strobe at the port 0 slew offset
	wire wr_slew = sfr_wr && sfr_addr == ppc_pkg::OFF_P0_SLEW;
	property p_pu_bit;
		wr_shr ##1 !reset_pin_disable_opt |->
			shared_pin_pullup_en == $past(sfr_wdata[7]);
	endproperty
	a_pu_bit: assert property (p_pu_bit)
		else $error("pull-up does not follow bit 7");
	property p_pu_rst; reset_pin_disable_opt |-> shared_pin_pullup_en;
	endproperty
	a_pu_rst: assert property (p_pu_rst)
		else $error("pull-up off while pin is reset");
	property p_mode; port3_input_only == (port3_mode == 2'b10); endproperty
	a_mode: assert property (p_mode)
		else $error("input-only decode wrong");
	property p_rst_mode; $rose(rst_n) |-> port3_mode == 2'b10; endproperty
	a_rst_mode: assert property (p_rst_mode)
		else $error("port 3 mode wrong after reset");
	property p_slew_wr; wr_slew && sfr_page |=> port0_slew_fast ==
		$past(sfr_wdata); endproperty
	a_slew_wr: assert property (p_slew_wr)
		else $error("slew write lost");
	property p_slew_pg0; wr_slew && !sfr_page |=> $stable(port0_slew_fast);
	endproperty
	a_slew_pg0: assert property (p_slew_pg0)
		else $error("slew changed by page 0 write");
	property p_tgl; timer0_toggle_out_en && timer0_overflow && !sfr_wr |=>
		timer0_pin_out != $past(timer0_pin_out); endproperty
	a_tgl: assert property (p_tgl)
		else $error("timer 0 pin did not toggle");
	property p_pin; shared_pin_data ==
		(!reset_pin_disable_opt && shared_pin_in); endproperty
	a_pin: assert property (p_pin)
		else $error("shared pin data wrong");
	property p_unimp; sfr_rd && sfr_addr == ppc_pkg::OFF_SHARED_SET |=>
		(sfr_rdata & ~ppc_pkg::MASK_SHARED) == 8'h00; endproperty
	a_unimp: assert property (p_unimp)
		else $error("unused bits read nonzero");
	c_ovf: cover property (timer0_toggle_out_en && timer0_overflow);
	c_opt: cover property (reset_pin_disable_opt && shared_pin_pullup_en);
	c_rd: cover property (sfr_rd && sfr_hit);
endmodule // ppc_asserts

bind ppc_port_pin_config_regs ppc_asserts u_chk (
	.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
	.reset_pin_disable_opt(reset_pin_disable_opt),
	.shared_pin_in(shared_pin_in), .shared_pin_data(shared_pin_data),
	.shared_pin_pullup_en(shared_pin_pullup_en),
	.port3_mode(port3_mode), .port3_input_only(port3_input_only),
	.port0_slew_fast(port0_slew_fast),
	.timer0_overflow(timer0_overflow),
	.timer0_toggle_out_en(timer0_toggle_out_en),
	.timer0_pin_out(timer0_pin_out)
);

//--- verification/ppc_port_pin_config_regs_tb_top.sv
// Self-checking bench of the port pin configuration registers
`timescale 1ns/1ps
module ppc_port_pin_config_regs_tb_top;
	logic clock, rst_n, sfr_page, sfr_wr, sfr_rd, shared_pin_in;
	logic reset_pin_disable_opt, timer0_overflow, timer1_overflow;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic sfr_hit, shared_pin_data, shared_pin_pullup_en;
	logic shared_pin_schmitt_sel, port3_quasi_bidir, port3_push_pull;
	logic port3_input_only, port3_open_drain, port3_schmitt;
	logic [1:0] port3_mode;
	logic [7:0] port0_schmitt, port1_schmitt, port0_slew_fast;
	logic [7:0] port1_slew_fast;
	logic timer0_toggle_out_en, timer1_toggle_out_en, timer0_pin_out;
	logic timer1_pin_out, timer0_pin_oe, timer1_pin_oe;
	int err_total, num_checks, cyc;
	// Page 1 offsets and their implemented bits
	logic [7:0] ra [6] = '{8'hAC, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5};
	logic [7:0] rm [6] = '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h8D};
	ppc_port_pin_config_regs dut (
		.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
		.reset_pin_disable_opt(reset_pin_disable_opt),
		.shared_pin_in(shared_pin_in), .shared_pin_data(shared_pin_data),
		.shared_pin_pullup_en(shared_pin_pullup_en),
		.shared_pin_schmitt_sel(shared_pin_schmitt_sel),
		.port3_mode(port3_mode), .port3_quasi_bidir(port3_quasi_bidir),
		.port3_push_pull(port3_push_pull),
		.port3_input_only(port3_input_only),
		.port3_open_drain(port3_open_drain),
		.port3_schmitt(port3_schmitt), .port0_schmitt(port0_schmitt),
		.port1_schmitt(port1_schmitt), .port0_slew_fast(port0_slew_fast),
		.port1_slew_fast(port1_slew_fast),
		.timer0_overflow(timer0_overflow),
		.timer1_overflow(timer1_overflow),
		.timer0_toggle_out_en(timer0_toggle_out_en),
		.timer1_toggle_out_en(timer1_toggle_out_en),
		.timer0_pin_out(timer0_pin_out), .timer1_pin_out(timer1_pin_out),
		.timer0_pin_oe(timer0_pin_oe), .timer1_pin_oe(timer1_pin_oe)
	);
	// Free-running clock
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	// Hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			summarize();
		end
	end
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	// One write strobe
	task automatic wrt(logic p, logic [7:0] a, logic [7:0] d);
		sfr_page = p;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge clock);
		sfr_wr = 0;
		@(negedge clock);
	endtask
	// One read strobe, data checked after its edge
	task automatic rdc(logic p, logic [7:0] a, logic [7:0] e);
		sfr_page = p;
		sfr_addr = a;
		sfr_rd = 1;
		@(negedge clock);
		sfr_rd = 0;
		chk("rdata", sfr_rdata, e);
		@(negedge clock);
	endtask
	// Overflow pulses for n cycles
	task automatic ovf(logic a, logic b, int n);
		timer0_overflow = a;
		timer1_overflow = b;
		repeat (n) @(negedge clock);
		timer0_overflow = 0;
		timer1_overflow = 0;
		@(negedge clock);
	endtask
	function automatic logic [7:0] tp();
		return {4'h0, timer0_pin_out, timer1_pin_out, timer0_pin_oe,
			timer1_pin_oe};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{rst_n, sfr_page, sfr_wr, sfr_rd, shared_pin_in} = 0;
		{reset_pin_disable_opt, timer0_overflow, timer1_overflow} = 0;
		sfr_addr = 0;
		sfr_wdata = 0;
		repeat (16) @(negedge clock);
		rst_n = 1;
		// Reset values
		rdc(0, 8'hAC, 8'h01);
		rdc(0, 8'hAD, 8'h00);
		chk("hit", 8'(sfr_hit), 8'h01);
		chk("mode", 8'(port3_mode), 8'h02);
		chk("pins", tp(), 8'h0C);
		chk("pu", 8'(shared_pin_pullup_en), 8'h00);
		for (int i = 0; i < 6; i++)
			rdc(1, ra[i], 8'h00);
		$display("reset test done");
		// Page 1 registers, unused bits and per-pin values
		for (int i = 0; i < 6; i++) begin
			wrt(1, ra[i], 8'hFF);
			rdc(1, ra[i], rm[i]);
			wrt(1, ra[i], 8'hA5);
			rdc(1, ra[i], 8'hA5 & rm[i]);
		end
		chk("p0thr", port0_schmitt, 8'hA5);
		chk("p1thr", port1_schmitt, 8'hA5);
		chk("p3thr", 8'(port3_schmitt), 8'h01);
		chk("p0fast", port0_slew_fast, 8'hA5);
		chk("p1fast", port1_slew_fast, 8'hA5);
		chk("sel", 8'(shared_pin_schmitt_sel), 8'h01);
		$display("page 1 test done");
		// Page 0 must not reach page 1 registers
		wrt(0, 8'hB2, 8'h00);
		chk("p0fast", port0_slew_fast, 8'hA5);
		rdc(0, 8'hB1, 8'h00);
		chk("hit", 8'(sfr_hit), 8'h00);
		wrt(0, 8'hAC, 8'h00);
		rdc(1, 8'hAC, 8'h01);
		chk("hit", 8'(sfr_hit), 8'h01);
		for (int m = 0; m < 4; m++) begin
			wrt(0, 8'hAC, 8'(m >> 1));
			wrt(0, 8'hAD, 8'(m & 1));
			chk("mode", 8'(port3_mode), 8'(m));
			chk("hot", {4'h0, port3_open_drain, port3_input_only,
				port3_push_pull, port3_quasi_bidir}, 8'(1 << m));
		end
		rdc(0, 8'hAC, 8'h01);
		rdc(1, 8'hAD, 8'h00);
		chk("hit", 8'(sfr_hit), 8'h00);
		$display("mode test done");
		// Shared pin pull-up and data
		chk("pu", 8'(shared_pin_pullup_en), 8'h01);
		wrt(1, 8'hB5, 8'h00);
		chk("pu", 8'(shared_pin_pullup_en), 8'h00);
		shared_pin_in = 1;
		reset_pin_disable_opt = 1;
		@(negedge clock);
		chk("pu", 8'(shared_pin_pullup_en), 8'h01);
		chk("pin", 8'(shared_pin_data), 8'h00);
		reset_pin_disable_opt = 0;
		@(negedge clock);
		chk("pin", 8'(shared_pin_data), 8'h01);
		shared_pin_in = 0;
		@(negedge clock);
		chk("pin", 8'(shared_pin_data), 8'h00);
		$display("shared pin test done");
		// Timer toggle outputs
		wrt(0, 8'hB5, 8'h0C);
		chk("pins", tp(), 8'h0F);
		chk("en", {6'h00, timer1_toggle_out_en,
			timer0_toggle_out_en}, 8'h03);
		ovf(1, 0, 1);
		chk("pins", tp(), 8'h07);
		ovf(0, 1, 1);
		chk("pins", tp(), 8'h03);
		wrt(0, 8'hB5, 8'h04);
		chk("pins", tp(), 8'h06);
		chk("en", {6'h00, timer1_toggle_out_en,
			timer0_toggle_out_en}, 8'h01);
		ovf(0, 1, 1);
		chk("pins", tp(), 8'h06);
		ovf(1, 0, 3);
		chk("pins", tp(), 8'h0E);
		$display("timer test done");
		// Reset in mid-run restores every default
		rst_n = 0;
		repeat (2) @(negedge clock);
		rst_n = 1;
		chk("pins", tp(), 8'h0C);
		chk("mode", 8'(port3_mode), 8'h02);
		rdc(1, 8'hB2, 8'h00);
		$display("second reset test done");
		summarize();
	end
endmodule // ppc_port_pin_config_regs_tb_top
